/* pss_pkg.sv */
package pss_pkg;

  // Register word offsets (byte addresses on the Wishbone bus).
  localparam logic [7:0] PSS_OFF_TMRSEL   = 8'h00;
  localparam logic [7:0] PSS_OFF_SHDN     = 8'h04;
  localparam logic [7:0] PSS_OFF_RSTDLY   = 8'h08;
  localparam logic [7:0] PSS_OFF_STEER    = 8'h0C;
  localparam logic [7:0] PSS_OFF_CHCTRL   = 8'h10;
  localparam logic [7:0] PSS_OFF_IRQ_STAT = 8'h14;
  localparam logic [7:0] PSS_OFF_IRQ_MASK = 8'h18;

  // Reset values.
  localparam logic [7:0] PSS_RST_TMRSEL = 8'h00;
  localparam logic [7:0] PSS_RST_SHDN   = 8'h00;
  localparam logic [7:0] PSS_RST_RSTDLY = 8'h00;
  localparam logic [7:0] PSS_RST_STEER  = 8'h01;
  localparam logic [7:0] PSS_RST_CHCTRL = 8'h00;

  // Field positions.
  localparam int PSS_SHDN_STATUS_BIT = 7;
  localparam int PSS_SHDN_SRC_LSB    = 4;
  localparam int PSS_SHDN_AC_LSB     = 2;
  localparam int PSS_SHDN_BD_LSB     = 0;
  localparam int PSS_RESTART_BIT     = 7;
  localparam int PSS_STEER_SYNC_BIT  = 4;
  localparam int PSS_CH_CFG_LSB      = 6;
  localparam int PSS_CH_MODE_LSB     = 0;

  // Steering implemented bit mask.
  localparam logic [7:0] PSS_STEER_MASK = 8'h1F;
  localparam logic [1:0] PSS_MODE_PWM   = 2'h3;
  localparam logic [1:0] PSS_CFG_SINGLE = 2'h0;
  localparam logic [1:0] PSS_CFG_FWD    = 2'h1;
  localparam logic [1:0] PSS_CFG_HALF   = 2'h2;

  // Time-base encodings.
  localparam logic [1:0] PSS_TB_T2 = 2'h0;
  localparam logic [1:0] PSS_TB_T4 = 2'h1;
  localparam logic [1:0] PSS_TB_T6 = 2'h2;

  // Instruction cycle = 4 system clocks (Fosc/4 with Fosc = clock).
  localparam int         PSS_INSTR_CLKS = 4;
  localparam logic [1:0] PSS_PHASE_LAST = 2'h3;

  // Interrupt status bits.
  localparam int PSS_IRQ_SHDN_SET = 0;
  localparam int PSS_IRQ_SHDN_CLR = 1;

  typedef enum logic [1:0] {
    PSS_RUN,
    PSS_SHUT
  } pss_state_e;

endpackage

/* pss_ctrl.sv */
`timescale 1ns/10ps
// Notes on behaviour
// - Timer select: four 2-bit fields, channel 4 on top.
// - Field 00/01/10 picks timer 2/4/6; 11 reserved.
// - Status bit 7 set while outputs are shut down.
// - Source 000 off, 001 C1, 010 C2, 011 either.
// - Sources 1xx add fault pin low.
// - Shutdown A/C: 00 low, 01 high, 1x tri-state.
// - Shutdown B/D: 00 low, 01 high, 1x tri-state.
// - Synced comparator trips via timer 1 only.
// - Restart enabled: status self-clears when source goes.
// - Restart disabled: only software clear restarts PWM.
// - Delay active edge by programmed instruction cycles.
// - Steering updates at period start or instruction boundary.
// - Steer bit routes PWM with polarity, else port.
// - Steering only in PWM mode single-output configuration.
// - Steering top three bits read zero, ignore writes.
// - Output config selects single, forward, half, reverse.
// - Modes 11xx are PWM; low bits set polarity.
module pss_ctrl #(
  parameter int DELAY_W = 7
) (
  input  wire logic       clk_sys_in,
  input  wire logic       rst_in,
  input  wire logic [7:0] wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  output logic      [31:0] wb_dat_out,
  input  wire logic       wb_we_in,
  input  wire logic [3:0] wb_sel_in,
  input  wire logic       wb_cyc_in,
  input  wire logic       wb_stb_in,
  output logic            wb_ack_out,
  output logic            irq_out,
  input  wire logic [2:0] pwm_raw_in,
  input  wire logic [2:0] period_start_in,
  input  wire logic [2:0] dead_band_b_in,
  input  wire logic       cmp1_in,
  input  wire logic       cmp2_in,
  input  wire logic       cmp1_sync_in,
  input  wire logic       cmp2_sync_in,
  input  wire logic       comparator_sync_en1_in,
  input  wire logic       comparator_sync_en2_in,
  input  wire logic       fault_input_n_in,
  input  wire logic [3:0] port_data_in,
  output logic [1:0]      chan1_timebase_sel_out,
  output logic [1:0]      chan2_timebase_sel_out,
  output logic [1:0]      chan3_timebase_sel_out,
  output logic [1:0]      chan4_timebase_sel_out,
  output logic            pwm_out_a_out,
  output logic            pwm_out_b_out,
  output logic            pwm_out_c_out,
  output logic            pwm_out_d_out,
  output logic [3:0]      pwm_oe_out
);
  import pss_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  logic [7:0] tmrsel_reg;
  logic [7:0] shdn_cfg_reg;
  logic       shdn_status_reg;
  logic [7:0] rstdly_reg;
  logic [7:0] steer_reg;
  logic [4:0] steer_act_reg;
  logic [7:0] chctrl_reg;
  logic [1:0] irq_stat_reg;
  logic [1:0] irq_mask_reg;
  logic [1:0] phase_reg;
  logic [DELAY_W+1:0] dly_cnt_reg;
  logic       pwm_dly_reg;
  logic       pwm_prev_reg;
  logic [3:0] pin_val_reg;
  logic [3:0] pin_oe_reg;
  pss_state_e state_reg;

  logic       wr_en;
  logic       rd_en;
  logic       src_active;
  logic       sw_clr;
  logic       instr_edge;
  logic       pwm_sel;
  logic       period_sel;
  logic       dbb_sel;
  logic [1:0] cfg;
  logic [1:0] mode_hi;
  logic       pol_ac;
  logic       pol_bd;

  // Picks the channel 1 PWM, period-start or dead-band B bit from its time-base field.
  function automatic logic pick_tb(input logic [1:0] fld,
                                   input logic [2:0] vec);
    case (fld)
      PSS_TB_T2: pick_tb = vec[0];
      PSS_TB_T4: pick_tb = vec[1];
      PSS_TB_T6: pick_tb = vec[2];
      default:   pick_tb = 1'b0;
    endcase
  endfunction

  // Shutdown pin level from a 2-bit state field.
  function automatic logic [1:0] shdn_pin(input logic [1:0] fld);
    shdn_pin = fld[1] ? 2'b00 : {1'b1, fld[0]};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone classic slave, one wait state free: ack in the cycle after stb.
  assign wr_en = wb_cyc_in & wb_stb_in & wb_we_in & ~wb_ack_out & wb_sel_in[0];
  assign rd_en = wb_cyc_in & wb_stb_in & ~wb_we_in & ~wb_ack_out;

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= wb_cyc_in & wb_stb_in & ~wb_ack_out;
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (rd_en) begin
      case (wb_adr_in)
        PSS_OFF_TMRSEL: wb_dat_out <= {24'h00_0000, tmrsel_reg};
        PSS_OFF_SHDN:   wb_dat_out <= {24'h00_0000, shdn_status_reg,
                                       shdn_cfg_reg[6:0]};
        PSS_OFF_RSTDLY: wb_dat_out <= {24'h00_0000, rstdly_reg};
        PSS_OFF_STEER:  wb_dat_out <= {24'h00_0000, steer_reg};
        PSS_OFF_CHCTRL: wb_dat_out <= {24'h00_0000, chctrl_reg};
        PSS_OFF_IRQ_STAT: wb_dat_out <= {30'h0000_0000, irq_stat_reg};
        PSS_OFF_IRQ_MASK: wb_dat_out <= {30'h0000_0000, irq_mask_reg};
        default:        wb_dat_out <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tmrsel_reg   <= PSS_RST_TMRSEL;
      shdn_cfg_reg <= PSS_RST_SHDN;
      rstdly_reg   <= PSS_RST_RSTDLY;
      steer_reg    <= PSS_RST_STEER;
      chctrl_reg   <= PSS_RST_CHCTRL;
      irq_mask_reg <= 2'h0;
    end else if (wr_en) begin
      case (wb_adr_in)
        PSS_OFF_TMRSEL: tmrsel_reg   <= wb_dat_in[7:0];
        PSS_OFF_SHDN:   shdn_cfg_reg <= wb_dat_in[7:0];
        PSS_OFF_RSTDLY: rstdly_reg   <= wb_dat_in[7:0];
        PSS_OFF_STEER:  steer_reg <= wb_dat_in[7:0] & PSS_STEER_MASK;
        PSS_OFF_CHCTRL: chctrl_reg   <= wb_dat_in[7:0];
        PSS_OFF_IRQ_MASK: irq_mask_reg <= wb_dat_in[1:0];
        default: ;
      endcase
    end
  end

  assign chan1_timebase_sel_out = tmrsel_reg[1:0];
  assign chan2_timebase_sel_out = tmrsel_reg[3:2];
  assign chan3_timebase_sel_out = tmrsel_reg[5:4];
  assign chan4_timebase_sel_out = tmrsel_reg[7:6];

  ////////////////////////////////////////////////////////////////////////////
  // Instruction-cycle phase; one instruction cycle is four clocks.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      phase_reg <= 2'h0;
    end else begin
      phase_reg <= phase_reg + 2'h1;
    end
  end
  assign instr_edge = (phase_reg == PSS_PHASE_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Shutdown source decode. Synced comparators use the timer-1 copy.
  always_comb begin
    logic c1;
    logic c2;
    c1 = comparator_sync_en1_in ? cmp1_sync_in : cmp1_in;
    c2 = comparator_sync_en2_in ? cmp2_sync_in : cmp2_in;
    case (shdn_cfg_reg[6:4])
      3'h0: src_active = 1'b0;
      3'h1: src_active = c1;
      3'h2: src_active = c2;
      3'h3: src_active = c1 | c2;
      3'h4: src_active = ~fault_input_n_in;
      3'h5: src_active = ~fault_input_n_in | c1;
      3'h6: src_active = ~fault_input_n_in | c2;
      default: src_active = ~fault_input_n_in | c1 | c2;
    endcase
  end

  assign sw_clr = wr_en && wb_adr_in == PSS_OFF_SHDN
                  && !wb_dat_in[PSS_SHDN_STATUS_BIT];

  // A live source wins over a software clear so no trip is lost.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      shdn_status_reg <= 1'b0;
      state_reg       <= PSS_RUN;
    end else begin
      case (state_reg)
        PSS_RUN: begin
          if (src_active) begin
            shdn_status_reg <= 1'b1;
            state_reg       <= PSS_SHUT;
          end
        end
        PSS_SHUT: begin
          if (!src_active && rstdly_reg[PSS_RESTART_BIT]) begin
            shdn_status_reg <= 1'b0;
            state_reg       <= PSS_RUN;
          end else if (!src_active && sw_clr) begin
            shdn_status_reg <= 1'b0;
            state_reg       <= PSS_RUN;
          end
        end
        default: state_reg <= PSS_RUN;
      endcase
    end
  end

  // Sticky events: shutdown entered and left; write one to clear.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      irq_stat_reg <= 2'h0;
    end else begin
      logic [1:0] clr;
      logic [1:0] set;
      clr = (wr_en && wb_adr_in == PSS_OFF_IRQ_STAT) ? wb_dat_in[1:0] : 2'h0;
      set = {state_reg == PSS_SHUT && !src_active &&
             (rstdly_reg[PSS_RESTART_BIT] || sw_clr),
             state_reg == PSS_RUN && src_active};
      irq_stat_reg <= (irq_stat_reg & ~clr) | set;
    end
  end
  assign irq_out = |(irq_stat_reg & irq_mask_reg);

  ////////////////////////////////////////////////////////////////////////////
  // Channel 1 PWM selection and active-edge delay.
  assign pwm_sel    = pick_tb(tmrsel_reg[1:0], pwm_raw_in);
  assign period_sel = pick_tb(tmrsel_reg[1:0], period_start_in);
  assign dbb_sel    = pick_tb(tmrsel_reg[1:0], dead_band_b_in);

  // The rising edge waits delay x 4 clocks; falling edges pass at once.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pwm_prev_reg <= 1'b0;
      pwm_dly_reg  <= 1'b0;
      dly_cnt_reg  <= '0;
    end else begin
      pwm_prev_reg <= pwm_sel;
      if (!pwm_sel) begin
        pwm_dly_reg <= 1'b0;
        dly_cnt_reg <= '0;
      end else if (!pwm_prev_reg) begin
        dly_cnt_reg <= (DELAY_W+2)'(rstdly_reg[DELAY_W-1:0]) << 2;
        pwm_dly_reg <= (rstdly_reg[DELAY_W-1:0] == '0);
      end else if (dly_cnt_reg > (DELAY_W+2)'(1)) begin
        dly_cnt_reg <= dly_cnt_reg - (DELAY_W+2)'(1);
      end else begin
        dly_cnt_reg <= '0;
        pwm_dly_reg <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Steering enables latch at period start or instruction boundary.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      steer_act_reg <= PSS_RST_STEER[4:0];
    end else if (steer_reg[PSS_STEER_SYNC_BIT] ? period_sel : instr_edge) begin
      steer_act_reg <= steer_reg[4:0];
    end
  end

  assign cfg     = chctrl_reg[PSS_CH_CFG_LSB +: 2];
  assign mode_hi = chctrl_reg[PSS_CH_MODE_LSB+2 +: 2];
  // Mode bit 1 sets the A/C active level and bit 0 the B/D level.
  // A one means active-low.
  assign pol_ac  = chctrl_reg[PSS_CH_MODE_LSB+1];
  assign pol_bd  = chctrl_reg[PSS_CH_MODE_LSB];

  // Pin drive, registered. Order of bits: d c b a.
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      pin_val_reg <= 4'h0;
      pin_oe_reg  <= 4'h0;
    end else begin
      logic [3:0] act;
      logic [3:0] en;
      logic [1:0] sac;
      logic [1:0] sbd;
      act = 4'h0;
      en  = 4'h0;
      sac = shdn_pin(shdn_cfg_reg[PSS_SHDN_AC_LSB +: 2]);
      sbd = shdn_pin(shdn_cfg_reg[PSS_SHDN_BD_LSB +: 2]);
      if (mode_hi == PSS_MODE_PWM) begin
        case (cfg)
          PSS_CFG_SINGLE: begin
            en  = steer_act_reg[3:0];
            act = {4{pwm_dly_reg}};
          end
          PSS_CFG_FWD: begin
            en  = 4'hF;
            act = {pwm_dly_reg, 2'b00, 1'b1};
          end
          PSS_CFG_HALF: begin
            en  = 4'h3;
            act = {2'b00, dbb_sel, pwm_dly_reg};
          end
          default: begin
            en  = 4'hF;
            act = {1'b0, 1'b1, pwm_dly_reg, 1'b0};
          end
        endcase
      end
      if (state_reg == PSS_SHUT) begin
        pin_val_reg <= {sbd[0], sac[0], sbd[0], sac[0]};
        pin_oe_reg  <= {sbd[1], sac[1], sbd[1], sac[1]};
      end else begin
        pin_oe_reg  <= 4'hF;
        for (int i = 0; i < 4; i++) begin
          if (en[i]) begin
            pin_val_reg[i] <= act[i] ^ (i[0] ? pol_bd : pol_ac);
          end else begin
            pin_val_reg[i] <= port_data_in[i];
          end
        end
      end
    end
  end

  assign pwm_out_a_out = pin_val_reg[0];
  assign pwm_out_b_out = pin_val_reg[1];
  assign pwm_out_c_out = pin_val_reg[2];
  assign pwm_out_d_out = pin_val_reg[3];
  assign pwm_oe_out    = pin_oe_reg;

  ////////////////////////////////////////////////////////////////////////////
  a_shdn_set_pins: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == PSS_RUN && src_active |=> shdn_status_reg ##1
    (pwm_oe_out[0] == !shdn_cfg_reg[3]))
    else $error("shutdown did not take the pins");
  a_status_state: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    shdn_status_reg == (state_reg == PSS_SHUT))
    else $error("status bit disagrees with state");
  a_auto_restart: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    shdn_status_reg && !src_active && rstdly_reg[7]
    |=> !shdn_status_reg)
    else $error("auto restart missing");
  a_hold_shutdown: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    shdn_status_reg && !rstdly_reg[7] && !sw_clr |=> shdn_status_reg)
    else $error("shutdown left without software clear");
  a_src_off: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    shdn_cfg_reg[6:4] == 3'h0 |-> !src_active)
    else $error("disabled source trips");
  a_fault_trip: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    shdn_cfg_reg[6] && !fault_input_n_in |-> src_active)
    else $error("fault pin ignored");
  a_steer_hi_zero: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $past(rd_en) && $past(wb_adr_in) == PSS_OFF_STEER
    |-> wb_dat_out[7:5] == 3'h0)
    else $error("steering top bits set");
  a_tristate_ac: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $past(state_reg) == PSS_SHUT && $past(shdn_cfg_reg[3])
    |-> !pwm_oe_out[0] && !pwm_oe_out[2])
    else $error("A/C not tri-stated");
  a_tristate_bd: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $past(state_reg) == PSS_SHUT && $past(shdn_cfg_reg[1])
    |-> !pwm_oe_out[1] && !pwm_oe_out[3])
    else $error("B/D not tri-stated");
  a_delay_edge: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(pwm_sel) && rstdly_reg[6:0] == 7'h01 |-> !pwm_dly_reg [*4])
    else $error("active edge came early");
endmodule

/* pss_far_side.sv */
`timescale 1ns/10ps
//////////////////////////////////////////////////////////////////////////////
// Stand-in for the comparators, the fault circuit and the power switches.
module pss_far_side #(
  parameter int SYNC_LAT = 6
) (
  input  wire logic       clk_sys_in,
  input  wire logic [2:0] trip_in,
  input  wire logic [3:0] pin_in,
  input  wire logic [3:0] oe_in,
  output logic            cmp1_out,
  output logic            cmp2_out,
  output logic            cmp1_sync_out,
  output logic            cmp2_sync_out,
  output logic            fault_n_out,
  output logic [3:0]      switch_out
);
  logic [SYNC_LAT-1:0] c1_pipe_reg;
  logic [SYNC_LAT-1:0] c2_pipe_reg;
  assign cmp1_out = trip_in[0];
  assign cmp2_out = trip_in[1];
  // The fault line has a pull-up, so an idle fault circuit reads high.
  assign fault_n_out = ~trip_in[2];
  // The resync path is deliberately slow so that an early trip shows up.
  always_ff @(posedge clk_sys_in) begin
    c1_pipe_reg <= {c1_pipe_reg[SYNC_LAT-2:0], trip_in[0]};
    c2_pipe_reg <= {c2_pipe_reg[SYNC_LAT-2:0], trip_in[1]};
  end
  assign cmp1_sync_out = c1_pipe_reg[SYNC_LAT-1];
  assign cmp2_sync_out = c2_pipe_reg[SYNC_LAT-1];
  // Gate pull-downs keep a switch off while its pin is not driven.
  assign switch_out = pin_in & oe_in;
endmodule

/* pss_ctrl_bench.sv */
`timescale 1ns/10ps
module pss_ctrl_bench;
  import pss_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        rst_in = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic [31:0] rdat, got;
  logic [3:0]  sel = 4'hF;
  logic        we = 1'b0;
  logic        stb = 1'b0;
  logic        ack, irq, c1, c2, c1s, c2s, flt_n;
  logic [2:0]  raw = 3'h0;
  logic [2:0]  pstart = 3'h0;
  logic [2:0]  trip = 3'h0;
  logic [2:0]  dbb = 3'h0;
  logic [1:0]  sync_en = 2'h0;
  logic [3:0]  port = 4'h0;
  logic [3:0]  oe, sw;
  logic [7:0]  tsel, v;
  logic        pa, pb, pc, pd;
  int          num_errors = 0;
  int          checks_done = 0;
  int          seed = 67;
  int          mdl[int];
  int          t0, t1, d;
  logic [1:0]  ac, bd;
  always #2 clk_sys_in = ~clk_sys_in;
  pss_ctrl i_pss_ctrl (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .wb_adr_in(adr), .wb_dat_in(wdat), .wb_dat_out(rdat), .wb_we_in(we),
    .wb_sel_in(sel), .wb_cyc_in(stb), .wb_stb_in(stb), .wb_ack_out(ack),
    .irq_out(irq), .pwm_raw_in(raw), .period_start_in(pstart),
    .dead_band_b_in(dbb), .cmp1_in(c1), .cmp2_in(c2), .cmp1_sync_in(c1s),
    .cmp2_sync_in(c2s), .comparator_sync_en1_in(sync_en[0]),
    .comparator_sync_en2_in(sync_en[1]), .fault_input_n_in(flt_n),
    .port_data_in(port), .chan1_timebase_sel_out(tsel[1:0]),
    .chan2_timebase_sel_out(tsel[3:2]), .chan3_timebase_sel_out(tsel[5:4]),
    .chan4_timebase_sel_out(tsel[7:6]), .pwm_out_a_out(pa),
    .pwm_out_b_out(pb), .pwm_out_c_out(pc), .pwm_out_d_out(pd),
    .pwm_oe_out(oe));
  pss_far_side i_pss_far_side (.clk_sys_in(clk_sys_in), .trip_in(trip),
    .pin_in({pd, pc, pb, pa}), .oe_in(oe), .cmp1_out(c1), .cmp2_out(c2),
    .cmp1_sync_out(c1s), .cmp2_sync_out(c2s), .fault_n_out(flt_n),
    .switch_out(sw));
  //////////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("Counts: checks_done=%0d num_errors=%0d", checks_done,
             num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_in);
  endtask
  // One classic cycle; the request stands until ack is seen at an edge.
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] x,
                     input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_sys_in);
    adr <= a;
    we <= w;
    wdat <= x;
    sel <= s;
    stb <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (ack !== 1'b1 && n < 100);
    if (n >= 100) num_errors++;
    got = rdat;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] x,
                    input logic [3:0] s = 4'hF);
    bus(a, 1'b1, {24'h0, x}, s);
    if (mdl.exists(a) && s[0])
      mdl[a] = x & ((a == PSS_OFF_STEER) ? PSS_STEER_MASK : 8'hFF);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus(a, 1'b0, 32'h0, 4'hF);
    chk(got, {24'h0, e});
  endtask
  task automatic rise_time(output int t);
    raw <= 3'h0;
    tick(8);
    raw <= 3'h7;
    t = 0;
    do begin
      @(posedge clk_sys_in);
      t++;
    end while (pa !== 1'b1 && t < 1000);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #200000;
    num_errors++;
    complete_run();
  end
  initial begin
    mdl[PSS_OFF_TMRSEL] = PSS_RST_TMRSEL;
    mdl[PSS_OFF_RSTDLY] = PSS_RST_RSTDLY;
    mdl[PSS_OFF_STEER] = PSS_RST_STEER;
    mdl[PSS_OFF_CHCTRL] = PSS_RST_CHCTRL;
    tick(10);
    rst_in <= 1'b0;
    foreach (mdl[k]) rd(k[7:0], mdl[k][7:0]);
    rd(PSS_OFF_SHDN, PSS_RST_SHDN);
    rd(8'h1C, 8'h00);
    $display("test reset values done");
    v = 8'($random(seed));
    wr(PSS_OFF_TMRSEL, v);
    wr(PSS_OFF_TMRSEL, ~v, 4'hE);
    rd(PSS_OFF_TMRSEL, v[7:0]);
    chk(tsel, v);
    wr(PSS_OFF_STEER, 8'hFF);
    rd(PSS_OFF_STEER, mdl[PSS_OFF_STEER][7:0]);
    $display("test register fields done");
    wr(PSS_OFF_CHCTRL, 8'h0C);
    wr(PSS_OFF_STEER, 8'h01);
    for (int t = 0; t < 3; t++) begin
      wr(PSS_OFF_TMRSEL, 8'(t));
      raw <= 3'(1 << t);
      tick(6);
      chk(pa, 1'b1);
      raw <= ~3'(1 << t);
      tick(6);
      chk(pa, 1'b0);
    end
    wr(PSS_OFF_CHCTRL, 8'h0E);
    raw <= 3'h7;
    tick(6);
    chk(pa, 1'b0);
    wr(PSS_OFF_CHCTRL, 8'h0C);
    wr(PSS_OFF_STEER, 8'h12);
    tick(8);
    chk({pb, pa}, 2'b01);
    pstart <= 3'h7;
    tick(1);
    pstart <= 3'h0;
    tick(4);
    chk({pb, pa}, 2'b10);
    wr(PSS_OFF_STEER, 8'h01);
    tick(8);
    chk({pb, pa}, 2'b01);
    $display("test steering done");
    // Bridge layouts; the reverse case runs B/D active-low.
    for (int f = 1; f < 4; f++) begin
      v = 8'($random(seed));
      dbb <= v[2:0];
      wr(PSS_OFF_CHCTRL, {2'(f), 2'b00, (f == 3) ? 4'hD : 4'hC});
      tick(6);
      chk({pd, pc, pb, pa},
          (f == 1) ? 4'h9 : ((f == 2) ? {2'b00, v[2], 1'b1} : 4'hC));
    end
    wr(PSS_OFF_CHCTRL, 8'h0C);
    $display("test output configurations done");
    rise_time(t0);
    d = 1 + ($unsigned($random(seed)) % 127);
    wr(PSS_OFF_RSTDLY, 8'(d));
    rise_time(t1);
    chk(t1 - t0, 4 * d);
    $display("test edge delay done");
    wr(PSS_OFF_RSTDLY, 8'h80);
    for (int c = 0; c < 8; c++) begin
      ac = 2'(c);
      bd = 2'(c + 1);
      wr(PSS_OFF_SHDN, {1'b0, 3'(c), ac, bd});
      trip <= ~3'(c);
      tick(6);
      rd(PSS_OFF_SHDN, {1'b0, 3'(c), ac, bd});
      trip <= 3'(c);
      tick(6);
      rd(PSS_OFF_SHDN, {c != 0, 3'(c), ac, bd});
      if (c != 0) begin
        chk(oe, {~bd[1], ~ac[1], ~bd[1], ~ac[1]});
        chk(sw, {bd == 2'h1, ac == 2'h1, bd == 2'h1, ac == 2'h1});
      end
      trip <= 3'h0;
      tick(6);
      rd(PSS_OFF_SHDN, {1'b0, 3'(c), ac, bd});
    end
    $display("test shutdown sources done");
    wr(PSS_OFF_IRQ_MASK, 8'h03);
    wr(PSS_OFF_IRQ_STAT, 8'h03);
    rd(PSS_OFF_IRQ_STAT, 8'h00);
    wr(PSS_OFF_RSTDLY, 8'h00);
    wr(PSS_OFF_SHDN, 8'h40);
    trip <= 3'h4;
    tick(6);
    trip <= 3'h0;
    tick(6);
    rd(PSS_OFF_SHDN, 8'hC0);
    chk(irq, 1'b1);
    wr(PSS_OFF_SHDN, 8'h40);
    rd(PSS_OFF_SHDN, 8'h40);
    rd(PSS_OFF_IRQ_STAT, 8'h03);
    wr(PSS_OFF_IRQ_STAT, 8'h01);
    rd(PSS_OFF_IRQ_STAT, 8'h02);
    wr(PSS_OFF_IRQ_MASK, 8'h01);
    chk(irq, 1'b0);
    wr(PSS_OFF_IRQ_STAT, 8'h02);
    rd(PSS_OFF_IRQ_STAT, 8'h00);
    $display("test restart and interrupt done");
    sync_en <= 2'b01;
    wr(PSS_OFF_SHDN, 8'h10);
    raw <= 3'h7;
    tick(4);
    trip <= 3'h1;
    tick(3);
    chk(pa, 1'b1);
    tick(9);
    chk(pa, 1'b0);
    $display("test comparator resync done");
    complete_run();
  end
endmodule
